// ===== include/real_time_calendar_defines.svh
`ifndef REAL_TIME_CALENDAR_DEFINES_SVH
`define REAL_TIME_CALENDAR_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave
`define REAL_TIME_CALENDAR_CFG_OFS      8'h00
`define REAL_TIME_CALENDAR_VAL_OFS      8'h04
`define REAL_TIME_CALENDAR_ALVAL_OFS    8'h08
`define REAL_TIME_CALENDAR_ALCFG_OFS    8'h0c
`define REAL_TIME_CALENDAR_KEY_OFS      8'h10
`define REAL_TIME_CALENDAR_PAD_OFS      8'h14

// Field positions in clock_setup_and_trim
`define REAL_TIME_CALENDAR_RUN_BIT      15
`define REAL_TIME_CALENDAR_UNLOCK_BIT   13
`define REAL_TIME_CALENDAR_OE_BIT       10
`define REAL_TIME_CALENDAR_PTR_HI       9
`define REAL_TIME_CALENDAR_PTR_LO       8
// Field positions in the alarm setup and pad registers
`define REAL_TIME_CALENDAR_ALEN_BIT     15
`define REAL_TIME_CALENDAR_SRCSEL_BIT   1

// Reset values
`define REAL_TIME_CALENDAR_CFG_RST      16'h0000
`define REAL_TIME_CALENDAR_ALCFG_RST    16'h0000
`define REAL_TIME_CALENDAR_YEAR_RST     8'h00
`define REAL_TIME_CALENDAR_MONTH_RST    8'h01
`define REAL_TIME_CALENDAR_DAY_RST      8'h01
`define REAL_TIME_CALENDAR_WDAY_RST     8'h06
`define REAL_TIME_CALENDAR_ZERO_RST     8'h00

// Unlock key bytes
`define REAL_TIME_CALENDAR_KEY_FIRST    8'h55
`define REAL_TIME_CALENDAR_KEY_SECOND   8'haa

// Time base: 32768 pulses per second, prescaler top is that less one
`define REAL_TIME_CALENDAR_TB_HZ        32768
`define REAL_TIME_CALENDAR_PSC_TOP      16'sh7fff
`define REAL_TIME_CALENDAR_RIPPLE_START 16'sh7fe0
`define REAL_TIME_CALENDAR_TRIM_SHIFT   2

// BCD limits
`define REAL_TIME_CALENDAR_SEC_TOP      8'h59
`define REAL_TIME_CALENDAR_HOUR_TOP     8'h23
`define REAL_TIME_CALENDAR_WDAY_TOP     8'h06
`define REAL_TIME_CALENDAR_MONTH_TOP    8'h12
`define REAL_TIME_CALENDAR_YEAR_TOP     8'h99

`endif

// ===== include/real_time_calendar_pkg.sv
package real_time_calendar_pkg;
	// Unlock key sequence progress
	typedef enum logic [1:0] {key_idle, key_got_first, key_armed} real_time_calendar_key_state_t;
	// One BCD byte
	typedef logic [7:0] real_time_calendar_bcd_t;
endpackage : real_time_calendar_pkg

// ===== hdl/real_time_calendar_top.sv
// Function
// - Calendar spans 00:00:00 1 Jan 2000 to 23:59:59 31 Dec 2099.
// - Leap years detected automatically, 29 February inserted.
// - Hours 24-hour only; one-second steps with half-second visibility.
// - All time and calendar fields held and shown in BCD.
// - Timekeeping runs from an external 32.768 kHz time base.
// - Value pointer picks time pair: min/sec, wday/hour, month/day, year.
// - High-byte time window write decrements value pointer, holding at 00.
// - Any read of either window decrements its pointer.
// - Alarm pointer picks alarm pair; 11 selects nothing.
// - High-byte alarm window write decrements alarm pointer, holding at 00.
// - Time window writes ignored unless unlock bit 13 set.
// - Unlock bit set only right after 0x55 then 0xAA key writes.
// - Enable bit 15 runs the clock; writable only while unlocked.
// - Read-only ripple flag bit 12 high while rollover may occur.
// - Read-only half-second flag bit 11 high in second half.
// - Writing seconds byte clears half-second flag, restarting sub-second.
// - Output-enable bit 10 gates the clock output pin.
// - Configuration register reset only by power-on reset.
// - Eight-bit drift trim in bits 7..0 for monthly calibration.
// - Trim two's complement, four pulses per minute per step.
// - Source select: 1 seconds clock, 0 alarm pulse; driven only enabled.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`include "real_time_calendar_defines.svh"

module real_time_calendar_top (
	input  wire logic        mclk,            // System clock, 50 MHz
	input  wire logic        sys_rst,         // Power-on reset, async, high
	input  wire logic        soft_rst,        // Other resets, sync, high
	input  wire logic        tb_clk_pin,      // 32.768 kHz time base pin
	input  wire logic [7:0]  avs_address,     // Byte address
	input  wire logic        avs_read,        // Read request
	input  wire logic        avs_write,       // Write request
	input  wire logic [31:0] avs_writedata,   // Write data
	input  wire logic [3:0]  avs_byteenable,  // Byte lanes
	output logic      [31:0] avs_readdata,    // Read data
	output logic             avs_waitrequest, // Stall
	output logic             time_pin_out,    // Clock output pin level
	output logic             time_pin_oe      // Clock output pin enable
);

	// Time base synchroniser and edge detect
	logic tb_s1, tb_s2, tb_s3;
	logic tb_pulse;

	// Configuration, reset by power-on only
	logic       clock_run_enable, next_clock_run_enable;
	logic       value_write_unlock, next_value_write_unlock;
	logic       time_pin_output_enable, next_time_pin_output_enable;
	logic [1:0] value_window_pointer, next_value_window_pointer;
	logic [7:0] drift_trim, next_drift_trim;
	logic       pin_source_select, next_pin_source_select;

	// Bus, key and calendar state
	real_time_calendar_pkg::real_time_calendar_key_state_t key_st, next_key_st;
	logic [31:0]        next_readdata;
	logic               next_waitrequest;
	logic signed [15:0] psc, next_psc;
	real_time_calendar_pkg::real_time_calendar_bcd_t cal_sec, cal_min, cal_hour, cal_wday, cal_day, cal_mon, cal_year;
	real_time_calendar_pkg::real_time_calendar_bcd_t next_sec, next_min, next_hour, next_wday, next_day, next_mon, next_year;
	real_time_calendar_pkg::real_time_calendar_bcd_t alarm_seconds, alarm_minutes, alarm_hours, alarm_weekday, alarm_day, alarm_month;
	real_time_calendar_pkg::real_time_calendar_bcd_t next_asec, next_amin, next_ahour, next_awday, next_aday, next_amon;
	logic [15:0]        alarm_setup_repeat_reg, next_alcfg;
	logic               alarm_hold, next_alarm_hold;
	logic               next_pin_out, next_pin_oe;

	// Decoded bus terms
	logic       req, acc, wr_acc, rd_acc;
	logic       sel_cfg, sel_val, sel_alval, sel_alcfg, sel_key, sel_pad;
	logic       half_second_phase, rollover_ripple_flag, sec_tick;
	logic [1:0] alarm_window_pointer;

	// BCD increment with wrap: {carry, value}
	function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] top, input logic [7:0] base);
		logic [8:0] r;
		r = {1'b0, v};
		if (v == top) begin
			r = {1'b1, base};
		end else if (v[3:0] == 4'h9) begin
			r = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction : bcd_step

	// Last day of a month in BCD
	function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		logic [7:0] r;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
		             : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			8'h02:                      r = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
			default:                    r = 8'h31;
		endcase
		return r;
	endfunction : month_last

	// Bus decode and status terms
	assign req       = avs_read | avs_write;
	assign acc       = req & ~avs_waitrequest;
	assign wr_acc    = acc & avs_write;
	assign rd_acc    = acc & avs_read;
	assign sel_cfg   = avs_address == `REAL_TIME_CALENDAR_CFG_OFS;
	assign sel_val   = avs_address == `REAL_TIME_CALENDAR_VAL_OFS;
	assign sel_alval = avs_address == `REAL_TIME_CALENDAR_ALVAL_OFS;
	assign sel_alcfg = avs_address == `REAL_TIME_CALENDAR_ALCFG_OFS;
	assign sel_key   = avs_address == `REAL_TIME_CALENDAR_KEY_OFS;
	assign sel_pad   = avs_address == `REAL_TIME_CALENDAR_PAD_OFS;
	assign alarm_window_pointer = alarm_setup_repeat_reg[`REAL_TIME_CALENDAR_PTR_HI:`REAL_TIME_CALENDAR_PTR_LO];
	assign tb_pulse  = tb_s2 & ~tb_s3;
	// second tick and half-second from prescaler
	assign sec_tick  = clock_run_enable & tb_pulse & (psc == `REAL_TIME_CALENDAR_PSC_TOP);
	assign half_second_phase = ~psc[15] & psc[14];
	assign rollover_ripple_flag = clock_run_enable & (psc >= `REAL_TIME_CALENDAR_RIPPLE_START);

	// Configuration next values
	always_comb begin
		next_clock_run_enable       = clock_run_enable;
		next_value_write_unlock     = value_write_unlock;
		next_time_pin_output_enable = time_pin_output_enable;
		next_value_window_pointer   = value_window_pointer;
		next_drift_trim             = drift_trim;
		next_pin_source_select      = pin_source_select;
		if (wr_acc && sel_cfg) begin
			if (avs_byteenable[0]) begin
				next_drift_trim = avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				next_time_pin_output_enable = avs_writedata[`REAL_TIME_CALENDAR_OE_BIT];
				next_value_window_pointer   = avs_writedata[`REAL_TIME_CALENDAR_PTR_HI:`REAL_TIME_CALENDAR_PTR_LO];
				if (!avs_writedata[`REAL_TIME_CALENDAR_UNLOCK_BIT]) begin
					next_value_write_unlock = 1'b0;
				end else if (key_st == real_time_calendar_pkg::key_armed) begin
					next_value_write_unlock = 1'b1;
				end
				if (value_write_unlock) begin
					next_clock_run_enable = avs_writedata[`REAL_TIME_CALENDAR_RUN_BIT];
				end
			end
		end
		if ((rd_acc && sel_val) || (wr_acc && sel_val && avs_byteenable[1] && value_write_unlock)) begin
			if (value_window_pointer != 2'b00) begin
				next_value_window_pointer = value_window_pointer - 2'b01;
			end
		end
		if (wr_acc && sel_pad && avs_byteenable[0]) begin
			next_pin_source_select = avs_writedata[`REAL_TIME_CALENDAR_SRCSEL_BIT];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			clock_run_enable       <= 1'(`REAL_TIME_CALENDAR_CFG_RST >> `REAL_TIME_CALENDAR_RUN_BIT);
			value_write_unlock     <= 1'b0;
			time_pin_output_enable <= 1'b0;
			value_window_pointer   <= 2'b00;
			drift_trim             <= 8'h00;
			pin_source_select      <= 1'b0;
		end else begin
			clock_run_enable       <= next_clock_run_enable;
			value_write_unlock     <= next_value_write_unlock;
			time_pin_output_enable <= next_time_pin_output_enable;
			value_window_pointer   <= next_value_window_pointer;
			drift_trim             <= next_drift_trim;
			pin_source_select      <= next_pin_source_select;
		end
	end

	// Bus, key, calendar, alarm and pin next values
	always_comb begin
		logic [8:0] st;
		st                = 9'h000;
		next_waitrequest  = ~(req & avs_waitrequest);
		next_readdata     = avs_readdata;
		next_key_st       = key_st;
		next_psc          = psc;
		next_sec          = cal_sec;
		next_min          = cal_min;
		next_hour         = cal_hour;
		next_wday         = cal_wday;
		next_day          = cal_day;
		next_mon          = cal_mon;
		next_year         = cal_year;
		next_asec         = alarm_seconds;
		next_amin         = alarm_minutes;
		next_ahour        = alarm_hours;
		next_awday        = alarm_weekday;
		next_aday         = alarm_day;
		next_amon         = alarm_month;
		next_alcfg        = alarm_setup_repeat_reg;
		next_alarm_hold   = alarm_hold;
		// Read data captured while the request waits
		if (req && avs_waitrequest && avs_read) begin
			next_readdata = 32'h0000_0000;
			if (sel_cfg) begin
				next_readdata[15:0] = {clock_run_enable, 1'b0, value_write_unlock, rollover_ripple_flag,
					half_second_phase, time_pin_output_enable, value_window_pointer, drift_trim};
			end else if (sel_val) begin
				case (value_window_pointer)
					2'b00:   next_readdata[15:0] = {cal_min, cal_sec};
					2'b01:   next_readdata[15:0] = {cal_wday, cal_hour};
					2'b10:   next_readdata[15:0] = {cal_mon, cal_day};
					default: next_readdata[15:0] = {8'h00, cal_year};
				endcase
			end else if (sel_alval) begin
				case (alarm_window_pointer)
					2'b00:   next_readdata[15:0] = {alarm_minutes, alarm_seconds};
					2'b01:   next_readdata[15:0] = {alarm_weekday, alarm_hours};
					2'b10:   next_readdata[15:0] = {alarm_month, alarm_day};
					default: next_readdata[15:0] = 16'h0000;
				endcase
			end else if (sel_alcfg) begin
				next_readdata[15:0] = alarm_setup_repeat_reg;
			end else if (sel_pad) begin
				next_readdata[`REAL_TIME_CALENDAR_SRCSEL_BIT] = pin_source_select;
			end
		end
		// key sequence, armed for one access
		if (acc) begin
			if (key_st == real_time_calendar_pkg::key_armed) begin
				next_key_st = real_time_calendar_pkg::key_idle;
			end
			if (avs_write && sel_key && avs_byteenable[0]) begin
				case (key_st)
					real_time_calendar_pkg::key_got_first: next_key_st = (avs_writedata[7:0] == `REAL_TIME_CALENDAR_KEY_SECOND)
						? real_time_calendar_pkg::key_armed : real_time_calendar_pkg::key_idle;
					default: next_key_st = (avs_writedata[7:0] == `REAL_TIME_CALENDAR_KEY_FIRST)
						? real_time_calendar_pkg::key_got_first : real_time_calendar_pkg::key_idle;
				endcase
			end
		end
		if (soft_rst) begin
			next_key_st = real_time_calendar_pkg::key_idle;
		end
		if (clock_run_enable && tb_pulse) begin
			next_psc = psc + 16'sh0001;
		end
		if (sec_tick) begin
			next_psc = 16'sh0000;
			if (alarm_hold) begin
				next_alarm_hold = 1'b0;
			end
			if (alarm_setup_repeat_reg[`REAL_TIME_CALENDAR_ALEN_BIT] && cal_sec == alarm_seconds && cal_min == alarm_minutes
				&& cal_hour == alarm_hours && cal_wday == alarm_weekday && cal_day == alarm_day
				&& cal_mon == alarm_month) begin
				next_alarm_hold = 1'b1;
			end
			st = bcd_step(cal_sec, `REAL_TIME_CALENDAR_SEC_TOP, 8'h00);
			next_sec = st[7:0];
			if (st[8]) begin
				next_psc = 16'(signed'(drift_trim)) <<< `REAL_TIME_CALENDAR_TRIM_SHIFT;
				st = bcd_step(cal_min, `REAL_TIME_CALENDAR_SEC_TOP, 8'h00);
				next_min = st[7:0];
				if (st[8]) begin
					st = bcd_step(cal_hour, `REAL_TIME_CALENDAR_HOUR_TOP, 8'h00);
					next_hour = st[7:0];
					if (st[8]) begin
						st = bcd_step(cal_wday, `REAL_TIME_CALENDAR_WDAY_TOP, 8'h00);
						next_wday = st[7:0];
						st = bcd_step(cal_day, month_last(cal_mon, cal_year), 8'h01);
						next_day = st[7:0];
						if (st[8]) begin
							st = bcd_step(cal_mon, `REAL_TIME_CALENDAR_MONTH_TOP, 8'h01);
							next_mon = st[7:0];
							if (st[8]) begin
								st = bcd_step(cal_year, `REAL_TIME_CALENDAR_YEAR_TOP, 8'h00);
								next_year = st[7:0];
							end
						end
					end
				end
			end
		end
		if (wr_acc && sel_val && value_write_unlock) begin
			if (avs_byteenable[0]) begin
				case (value_window_pointer)
					2'b00: begin
						next_sec = avs_writedata[7:0];
						next_psc = 16'sh0000;
					end
					2'b01:   next_hour = avs_writedata[7:0];
					2'b10:   next_day  = avs_writedata[7:0];
					default: next_year = avs_writedata[7:0];
				endcase
			end
			if (avs_byteenable[1]) begin
				case (value_window_pointer)
					2'b00:   next_min  = avs_writedata[15:8];
					2'b01:   next_wday = avs_writedata[15:8];
					2'b10:   next_mon  = avs_writedata[15:8];
					default: next_mon  = cal_mon;
				endcase
			end
		end
		if (wr_acc && sel_alval) begin
			if (avs_byteenable[0]) begin
				case (alarm_window_pointer)
					2'b00:   next_asec  = avs_writedata[7:0];
					2'b01:   next_ahour = avs_writedata[7:0];
					2'b10:   next_aday  = avs_writedata[7:0];
					default: next_aday  = alarm_day;
				endcase
			end
			if (avs_byteenable[1]) begin
				case (alarm_window_pointer)
					2'b00:   next_amin  = avs_writedata[15:8];
					2'b01:   next_awday = avs_writedata[15:8];
					2'b10:   next_amon  = avs_writedata[15:8];
					default: next_amon  = alarm_month;
				endcase
			end
		end
		if (wr_acc && sel_alcfg) begin
			if (avs_byteenable[0]) begin
				next_alcfg[7:0] = avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				next_alcfg[15:8] = avs_writedata[15:8];
			end
		end
		// alarm pointer walks down to 00
		if ((rd_acc && sel_alval) || (wr_acc && sel_alval && avs_byteenable[1])) begin
			if (alarm_window_pointer != 2'b00) begin
				next_alcfg[`REAL_TIME_CALENDAR_PTR_HI:`REAL_TIME_CALENDAR_PTR_LO] = alarm_window_pointer - 2'b01;
			end
		end
		next_pin_oe  = time_pin_output_enable;
		next_pin_out = time_pin_output_enable & (pin_source_select ? half_second_phase : alarm_hold);
	end

	// Registers of the bus, calendar and pin
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tb_s1                  <= 1'b0;
			tb_s2                  <= 1'b0;
			tb_s3                  <= 1'b0;
			avs_waitrequest        <= 1'b1;
			avs_readdata           <= 32'h0000_0000;
			key_st                 <= real_time_calendar_pkg::key_idle;
			psc                    <= 16'sh0000;
			cal_sec                <= `REAL_TIME_CALENDAR_ZERO_RST;
			cal_min                <= `REAL_TIME_CALENDAR_ZERO_RST;
			cal_hour               <= `REAL_TIME_CALENDAR_ZERO_RST;
			cal_wday               <= `REAL_TIME_CALENDAR_WDAY_RST;
			cal_day                <= `REAL_TIME_CALENDAR_DAY_RST;
			cal_mon                <= `REAL_TIME_CALENDAR_MONTH_RST;
			cal_year               <= `REAL_TIME_CALENDAR_YEAR_RST;
			alarm_seconds          <= `REAL_TIME_CALENDAR_ZERO_RST;
			alarm_minutes          <= `REAL_TIME_CALENDAR_ZERO_RST;
			alarm_hours            <= `REAL_TIME_CALENDAR_ZERO_RST;
			alarm_weekday          <= `REAL_TIME_CALENDAR_ZERO_RST;
			alarm_day              <= `REAL_TIME_CALENDAR_DAY_RST;
			alarm_month            <= `REAL_TIME_CALENDAR_MONTH_RST;
			alarm_setup_repeat_reg <= `REAL_TIME_CALENDAR_ALCFG_RST;
			alarm_hold             <= 1'b0;
			time_pin_out           <= 1'b0;
			time_pin_oe            <= 1'b0;
		end else begin
			tb_s1                  <= tb_clk_pin;
			tb_s2                  <= tb_s1;
			tb_s3                  <= tb_s2;
			avs_waitrequest        <= next_waitrequest;
			avs_readdata           <= next_readdata;
			key_st                 <= next_key_st;
			psc                    <= next_psc;
			cal_sec                <= next_sec;
			cal_min                <= next_min;
			cal_hour               <= next_hour;
			cal_wday               <= next_wday;
			cal_day                <= next_day;
			cal_mon                <= next_mon;
			cal_year               <= next_year;
			alarm_seconds          <= next_asec;
			alarm_minutes          <= next_amin;
			alarm_hours            <= next_ahour;
			alarm_weekday          <= next_awday;
			alarm_day              <= next_aday;
			alarm_month            <= next_amon;
			alarm_setup_repeat_reg <= next_alcfg;
			alarm_hold             <= next_alarm_hold;
			time_pin_out           <= next_pin_out;
			time_pin_oe            <= next_pin_oe;
		end
	end

	// Checks on pointer, lock, flags and cascade
	ptr_read_dec_a: assert property (@(posedge mclk) disable iff (sys_rst)
		rd_acc && sel_val && value_window_pointer != 2'b00 && !wr_acc
		|=> value_window_pointer == $past(value_window_pointer) - 2'b01) else $error("value pointer missed read");
	ptr_write_dec_a: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_acc && sel_val && avs_byteenable[1] && value_write_unlock && value_window_pointer == 2'b00
		|=> value_window_pointer == 2'b00) else $error("value pointer left 00");
	alarm_ptr_dec_a: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_acc && sel_alval && avs_byteenable[1] && alarm_window_pointer != 2'b00
		|=> alarm_window_pointer == $past(alarm_window_pointer) - 2'b01) else $error("alarm pointer missed write");
	locked_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_acc && sel_val && !value_write_unlock |=> $stable(value_window_pointer)) else $error("locked write acted");
	unlock_key_a: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(value_write_unlock) |-> $past(key_st) == real_time_calendar_pkg::key_armed) else $error("unlock without key");
	enable_lock_a: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_acc && sel_cfg && !value_write_unlock |=> $stable(clock_run_enable)) else $error("enable changed locked");
	half_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_acc && sel_val && avs_byteenable[0] && value_write_unlock && value_window_pointer == 2'b00
		|=> !half_second_phase && psc == 16'sh0000) else $error("seconds write kept phase");
	pin_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!time_pin_output_enable |=> !time_pin_oe && !time_pin_out) else $error("pin driven while disabled");
	hour_range_a: assert property (@(posedge mclk) disable iff (sys_rst)
		sec_tick && cal_hour == 8'h23 && cal_min == 8'h59 && cal_sec == 8'h59 |=> cal_hour == 8'h00)
		else $error("hour did not wrap at 23");
	sec_wrap_a: assert property (@(posedge mclk) disable iff (sys_rst)
		sec_tick && cal_sec == 8'h59 && !wr_acc |=> cal_sec == 8'h00 && cal_min != $past(cal_min))
		else $error("minute carry lost");
	bus_answer_a: assert property (@(posedge mclk) disable iff (sys_rst)
		req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing");

endmodule : real_time_calendar_top

// ===== test/real_time_calendar_core_model.sv
`timescale 1ns/10ps
`include "real_time_calendar_defines.svh"

module real_time_calendar_core_model (
	input  wire logic        mclk,            // System clock
	input  wire logic        avs_waitrequest, // Slave stall
	input  wire logic [31:0] avs_readdata,    // Slave read data
	output logic      [7:0]  avs_address,     // Byte address
	output logic             avs_read,        // Read request
	output logic             avs_write,       // Write request
	output logic      [31:0] avs_writedata,   // Write data
	output logic      [3:0]  avs_byteenable   // Byte lanes
);
	// Idle bus at time zero
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
	end

	// Write held until the slave stops stalling
	task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= {2'b00, be};
		avs_write <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : wr

	// Read data taken at the accepting edge
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_byteenable <= 4'h3;
		avs_read <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata[15:0];
		avs_read <= 1'b0;
	endtask : rd

	task unlock(input logic [15:0] cfg);
		wr(`REAL_TIME_CALENDAR_KEY_OFS, 16'h0055, 2'b01);
		wr(`REAL_TIME_CALENDAR_KEY_OFS, 16'h00aa, 2'b01);
		wr(`REAL_TIME_CALENDAR_CFG_OFS, cfg | 16'h2000, 2'b11);
	endtask : unlock
endmodule : real_time_calendar_core_model

// ===== test/tb.sv
`timescale 1ns/10ps
`include "real_time_calendar_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end

module tb;
	logic        mclk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, tb_clk_pin = 1'b0, tb_run = 1'b0, tb_div = 1'b0;
	logic [7:0]  avs_address;
	logic        avs_read, avs_write, avs_waitrequest, time_pin_out, time_pin_oe;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic [15:0] r;
	int          failures = 0, comparisons = 0, cycles = 0;

	real_time_calendar_top DUT (.mclk(mclk), .sys_rst(sys_rst), .soft_rst(soft_rst), .tb_clk_pin(tb_clk_pin),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.time_pin_out(time_pin_out), .time_pin_oe(time_pin_oe));
	real_time_calendar_core_model M (.mclk(mclk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable));

	always #10 mclk = ~mclk;
	// Time base, one pulse per four system cycles
	always @(posedge mclk) begin
		if (tb_run) begin
			tb_div <= ~tb_div;
			if (tb_div) tb_clk_pin <= ~tb_clk_pin;
		end
	end
	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 80000) begin
			failures++;
			end_sim();
		end
	end

	task end_sim;
		if (failures == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim

	// Power-on values and locked writes
	task t_lock;
		M.rd(`REAL_TIME_CALENDAR_CFG_OFS, r); `CHK(r, 16'h0000)
		M.wr(`REAL_TIME_CALENDAR_VAL_OFS, 16'h1234, 2'b11);
		M.wr(`REAL_TIME_CALENDAR_CFG_OFS, 16'h8000, 2'b11);
		M.rd(`REAL_TIME_CALENDAR_VAL_OFS, r); `CHK(r, 16'h0000)
		M.rd(`REAL_TIME_CALENDAR_CFG_OFS, r); `CHK(r, 16'h0000)
		M.wr(`REAL_TIME_CALENDAR_KEY_OFS, 16'h0055, 2'b01);
		M.wr(`REAL_TIME_CALENDAR_KEY_OFS, 16'h00aa, 2'b01);
		M.rd(`REAL_TIME_CALENDAR_ALCFG_OFS, r);
		M.wr(`REAL_TIME_CALENDAR_CFG_OFS, 16'h2000, 2'b11);
		M.rd(`REAL_TIME_CALENDAR_CFG_OFS, r); `CHK(r, 16'h0000)
	endtask : t_lock

	// Pointer walk on writes and reads
	task t_ptr;
		logic [15:0] vals [4];
		vals = '{16'h0099, 16'h1231, 16'h0323, 16'h5958};
		M.unlock(16'h0300);
		M.rd(`REAL_TIME_CALENDAR_CFG_OFS, r); `CHK(r, 16'h2300)
		for (int i = 0; i < 4; i++) M.wr(`REAL_TIME_CALENDAR_VAL_OFS, vals[i], 2'b11);
		M.rd(`REAL_TIME_CALENDAR_CFG_OFS, r); `CHK(r[9:8], 2'b00)
		M.unlock(16'h0300);
		for (int i = 0; i < 4; i++) begin
			M.rd(`REAL_TIME_CALENDAR_VAL_OFS, r); `CHK(r, vals[i])
		end
		M.rd(`REAL_TIME_CALENDAR_VAL_OFS, r); `CHK(r, 16'h5958)
	endtask : t_ptr

	// Alarm pointer on high-byte write and read
	task t_alarm;
		M.wr(`REAL_TIME_CALENDAR_ALCFG_OFS, 16'h0200, 2'b11);
		M.wr(`REAL_TIME_CALENDAR_ALVAL_OFS, 16'h1231, 2'b10);
		M.rd(`REAL_TIME_CALENDAR_ALCFG_OFS, r); `CHK(r, 16'h0100)
		M.wr(`REAL_TIME_CALENDAR_ALCFG_OFS, 16'h0200, 2'b11);
		M.rd(`REAL_TIME_CALENDAR_ALVAL_OFS, r); `CHK(r, 16'h1201)
		M.rd(`REAL_TIME_CALENDAR_ALCFG_OFS, r); `CHK(r, 16'h0100)
	endtask : t_alarm

	// Half-second phase, pin and seconds restart
	task t_half;
		M.unlock(16'h8000);
		M.wr(`REAL_TIME_CALENDAR_VAL_OFS, 16'h0058, 2'b01);
		M.wr(`REAL_TIME_CALENDAR_CFG_OFS, 16'h8400, 2'b11);
		M.wr(`REAL_TIME_CALENDAR_PAD_OFS, 16'h0002, 2'b11);
		tb_run <= 1'b1;
		repeat (64000) @(posedge mclk);
		M.rd(`REAL_TIME_CALENDAR_CFG_OFS, r); `CHK(r, 16'h8400)
		`CHK({time_pin_oe, time_pin_out}, 2'b10)
		repeat (2000) @(posedge mclk);
		M.rd(`REAL_TIME_CALENDAR_CFG_OFS, r); `CHK(r, 16'h8c00)
		`CHK({time_pin_oe, time_pin_out}, 2'b11)
		M.unlock(16'h8400);
		M.wr(`REAL_TIME_CALENDAR_VAL_OFS, 16'h0058, 2'b01);
		M.rd(`REAL_TIME_CALENDAR_CFG_OFS, r); `CHK(r, 16'ha400)
		soft_rst <= 1'b1;
		@(posedge mclk);
		soft_rst <= 1'b0;
		M.rd(`REAL_TIME_CALENDAR_CFG_OFS, r); `CHK(r, 16'ha400)
	endtask : t_half

	initial begin
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		t_lock();
		t_ptr();
		t_alarm();
		t_half();
		end_sim();
	end
endmodule : tb
